/* lmc_top.v */
// What this block does
// - Low battery supply blocks every transmission onto the bus.
// - Battery first applied: enter Fail-safe with regulator on.
// - Reset output low on regulator undervoltage or watchdog failure; 4 ms reset.
// - Normal mode: low transmit drives bus dominant, high leaves it recessive.
// - Fail-safe: transmit pin becomes output, low after local or ignition wake.
// - Transmit low beyond 6 ms forces the driver recessive.
// - Driver re-enabled only after transmit high for more than 10 us.
// - Receive output mirrors bus in Normal: high recessive, low dominant.
// - Enable high gives Normal mode, both paths on, regulator full.
// - Enable falling with transmit high enters Silent, regulator kept on.
// - Enable falling with transmit low enters Sleep, regulator off.
// - Local wake input activity wakes from Sleep or Silent; idle high.
// - Watchdog-mode input low runs watchdog; high disables it.
// - Watchdog trigger taken on falling edge of the trigger input.
// - Receive output switched off while unpowered.
// - Wake sources: bus, local wake input and ignition input.
// - Bus fall, filtered dominant, then rise: remote wake, Fail-safe, receive low.
// - A reset pulse moves the device straight to Fail-safe unless it is unpowered.
// - Fail-safe holds, bus off, until enable high, then Normal.
// - Ignition low-to-high edge wakes after a 160 us debounce.
`timescale 1ns/1ps
`include "lmc_defines.vh"
module lmc_top #(
   // Timing counts in clock cycles; a bench may scale them down to save run time
   parameter [19:0] DOM_CYC   = `LMC_DOM_CYC,
   parameter [19:0] TXREL_CYC = `LMC_TXREL_CYC,
   parameter [19:0] RES_CYC   = `LMC_RES_CYC,
   parameter [19:0] IGN_CYC   = `LMC_DB_IGN_CYC,
   parameter [19:0] BUSW_CYC  = `LMC_BUS_WAKE_CYC,
   parameter [21:0] WDOG_CYC  = `LMC_WDOG_CYC
) (
   input  wire       I_MCLK,
   input  wire       I_RSTN,
   input  wire       I_BATTERY_OK,
   input  wire       I_VCC_OK,
   input  wire       I_TX_DATA_IN,
   input  wire       I_ENABLE,
   input  wire       I_LOCAL_WAKE_N,
   input  wire       I_IGNITION_WAKE_IN,
   input  wire       I_WDOG_MODE,
   input  wire       I_WDOG_TRIGGER_N,
   input  wire       I_BUS_IN,
   output reg        O_BUS_DRV_DOM,
   output reg        O_RX_DATA_OUT,
   output reg        O_RX_DATA_OE,
   output reg        O_TX_DATA_OUT,
   output reg        O_TX_DATA_OE,
   output reg        O_RESET_OUT_N_OUT,
   output reg        O_RESET_OUT_N_OE,
   output reg        O_REG_ON,
   output reg        O_INH,
   output reg  [1:0] O_WAKE_SRC
);
   // One-hot mode states
   localparam [4:0] ST_UNPWR = 5'h01;
   localparam [4:0] ST_FSAFE = 5'h02;
   localparam [4:0] ST_NORM  = 5'h04;
   localparam [4:0] ST_SILNT = 5'h08;
   localparam [4:0] ST_SLEEP = 5'h10;

   // Synchronised pin levels
   wire bat_ok;
   wire vcc_ok;
   wire tx_in;
   wire en_in;
   wire lwake_n;
   wire ign_in;
   wire wmode;
   wire trig_n;
   wire bus_in;

   lmc_sync3 #(.RST_VAL(1'b0)) u_s_bat (.i_clk(I_MCLK), .i_rstn(I_RSTN),
      .i_d(I_BATTERY_OK), .o_q(bat_ok));
   lmc_sync3 #(.RST_VAL(1'b0)) u_s_vcc (.i_clk(I_MCLK), .i_rstn(I_RSTN),
      .i_d(I_VCC_OK), .o_q(vcc_ok));
   lmc_sync3 #(.RST_VAL(1'b1)) u_s_tx (.i_clk(I_MCLK), .i_rstn(I_RSTN),
      .i_d(I_TX_DATA_IN), .o_q(tx_in));
   lmc_sync3 #(.RST_VAL(1'b0)) u_s_en (.i_clk(I_MCLK), .i_rstn(I_RSTN),
      .i_d(I_ENABLE), .o_q(en_in));
   lmc_sync3 #(.RST_VAL(1'b1)) u_s_lw (.i_clk(I_MCLK), .i_rstn(I_RSTN),
      .i_d(I_LOCAL_WAKE_N), .o_q(lwake_n));
   lmc_sync3 #(.RST_VAL(1'b0)) u_s_ign (.i_clk(I_MCLK), .i_rstn(I_RSTN),
      .i_d(I_IGNITION_WAKE_IN), .o_q(ign_in));
   lmc_sync3 #(.RST_VAL(1'b0)) u_s_wm (.i_clk(I_MCLK), .i_rstn(I_RSTN),
      .i_d(I_WDOG_MODE), .o_q(wmode));
   lmc_sync3 #(.RST_VAL(1'b1)) u_s_trg (.i_clk(I_MCLK), .i_rstn(I_RSTN),
      .i_d(I_WDOG_TRIGGER_N), .o_q(trig_n));
   lmc_sync3 #(.RST_VAL(1'b1)) u_s_bus (.i_clk(I_MCLK), .i_rstn(I_RSTN),
      .i_d(I_BUS_IN), .o_q(bus_in));

   reg  [4:0]  state_reg;
   reg  [4:0]  state_next;
   reg         en_d_reg;
   reg         tx_d_reg;
   reg         trig_d_reg;
   reg         ign_d_reg;
   reg         lw_d_reg;
   reg  [19:0] dom_cnt_reg;
   reg         dom_lock_reg;
   reg  [19:0] rel_cnt_reg;
   reg  [19:0] res_cnt_reg;
   reg  [21:0] wd_cnt_reg;
   reg         wd_fail_reg;
   reg  [19:0] ign_cnt_reg;
   reg         ign_arm_reg;
   reg  [19:0] busw_cnt_reg;
   reg         busw_ok_reg;
   reg  [1:0]  wsrc_reg;
   reg         rwake_reg;

   wire en_fall   = en_d_reg & ~en_in;
   wire trig_fall = trig_d_reg & ~trig_n;
   wire low_power = (state_reg == ST_SILNT) | (state_reg == ST_SLEEP);
   wire rst_low   = (res_cnt_reg != 20'h00000);
   wire lw_event  = lw_d_reg & ~lwake_n;
   wire ign_wake  = ign_arm_reg & (ign_cnt_reg == IGN_CYC);
   wire bus_wake  = busw_ok_reg & bus_in;

   // Edge history of the synchronised levels
   always @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         en_d_reg   <= 1'b0;
         tx_d_reg   <= 1'b1;
         trig_d_reg <= 1'b1;
         ign_d_reg  <= 1'b0;
         lw_d_reg   <= 1'b1;
      end else begin
         en_d_reg   <= en_in;
         tx_d_reg   <= tx_in;
         trig_d_reg <= trig_n;
         ign_d_reg  <= ign_in;
         lw_d_reg   <= lwake_n;
      end
   end

   // Mode state machine; reset output and supply loss take precedence
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_UNPWR: begin
            if (bat_ok) begin
               state_next = ST_FSAFE;
            end
         end
         ST_FSAFE: begin
            if (en_in && !rst_low) begin
               state_next = ST_NORM;
            end
         end
         ST_NORM: begin
            if (en_fall) begin
               state_next = tx_in ? ST_SILNT : ST_SLEEP;
            end
         end
         ST_SILNT, ST_SLEEP: begin
            if (lw_event || ign_wake || bus_wake || en_in) begin
               state_next = ST_FSAFE;
            end
         end
         default: begin
            state_next = ST_FSAFE;
         end
      endcase
      if (rst_low && state_reg != ST_UNPWR) begin
         state_next = ST_FSAFE;
      end
      if (!bat_ok) begin
         state_next = ST_UNPWR;
      end
   end

   always @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         state_reg <= ST_UNPWR;
      end else begin
         state_reg <= state_next;
      end
   end

   // Dominant time-out and release timer; lock lifts only after a long high
   always @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         dom_cnt_reg  <= 20'h00000;
         dom_lock_reg <= 1'b0;
         rel_cnt_reg  <= 20'h00000;
      end else begin
         if (tx_in) begin
            dom_cnt_reg <= 20'h00000;
         end else if (dom_cnt_reg != DOM_CYC) begin
            dom_cnt_reg <= dom_cnt_reg + 20'h00001;
         end
         if (!tx_in) begin
            rel_cnt_reg <= 20'h00000;
         end else if (rel_cnt_reg != TXREL_CYC) begin
            rel_cnt_reg <= rel_cnt_reg + 20'h00001;
         end
         if (!tx_in && dom_cnt_reg == DOM_CYC) begin
            dom_lock_reg <= 1'b1;
         end else if (tx_in && rel_cnt_reg == TXREL_CYC) begin
            dom_lock_reg <= 1'b0;
         end
      end
   end

   // Watchdog: a trigger must arrive within the period unless disabled
   always @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         wd_cnt_reg  <= 22'h000000;
         wd_fail_reg <= 1'b0;
      end else begin
         wd_fail_reg <= 1'b0;
         if (wmode || rst_low || state_reg == ST_UNPWR || low_power) begin
            wd_cnt_reg <= 22'h000000;
         end else if (trig_fall) begin
            wd_cnt_reg <= 22'h000000;
         end else if (wd_cnt_reg == WDOG_CYC) begin
            wd_cnt_reg  <= 22'h000000;
            wd_fail_reg <= 1'b1;
         end else begin
            wd_cnt_reg <= wd_cnt_reg + 22'h000001;
         end
      end
   end

   // Reset pulse: undervoltage or watchdog failure, restart on each cause
   always @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         res_cnt_reg <= RES_CYC;
      end else if (!bat_ok || !vcc_ok || wd_fail_reg) begin
         res_cnt_reg <= RES_CYC;
      end else if (rst_low) begin
         res_cnt_reg <= res_cnt_reg - 20'h00001;
      end
   end

   // Ignition debounce: rising edge arms, level must hold for the filter time
   always @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         ign_cnt_reg <= 20'h00000;
         ign_arm_reg <= 1'b0;
      end else begin
         if (ign_in && !ign_d_reg) begin
            ign_arm_reg <= 1'b1;
            ign_cnt_reg <= 20'h00000;
         end else if (!ign_in || ign_wake) begin
            ign_arm_reg <= 1'b0;
            ign_cnt_reg <= 20'h00000;
         end else if (ign_arm_reg) begin
            ign_cnt_reg <= ign_cnt_reg + 20'h00001;
         end
      end
   end

   // Bus wake filter: dominant must last the filter time before the rise
   always @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         busw_cnt_reg <= 20'h00000;
         busw_ok_reg  <= 1'b0;
      end else begin
         if (!low_power || bus_in) begin
            busw_cnt_reg <= 20'h00000;
            busw_ok_reg  <= 1'b0;
         end else if (busw_cnt_reg != BUSW_CYC) begin
            busw_cnt_reg <= busw_cnt_reg + 20'h00001;
         end else begin
            busw_ok_reg <= 1'b1;
         end
      end
   end

   // Last wake source and remote wake flag; new wake wins over clearing
   always @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         wsrc_reg  <= `LMC_WSRC_NONE;
         rwake_reg <= 1'b0;
      end else if (low_power && lw_event) begin
         wsrc_reg  <= `LMC_WSRC_LOCAL;
         rwake_reg <= 1'b0;
      end else if (low_power && ign_wake) begin
         wsrc_reg  <= `LMC_WSRC_IGN;
         rwake_reg <= 1'b0;
      end else if (low_power && bus_wake) begin
         wsrc_reg  <= `LMC_WSRC_BUS;
         rwake_reg <= 1'b1;
      end else if (state_reg == ST_NORM) begin
         rwake_reg <= 1'b0;
      end
   end

   // Two-entry skid buffer on the transmit path; once a driver stall fills it, new samples are dropped
   wire       buf_in_valid = (tx_in != tx_d_reg) | 1'b1;
   wire       buf_in_ready;
   wire       buf_out_valid;
   wire       buf_out_data;
   wire       drv_ready    = ~dom_lock_reg | tx_in;
   lmc_buf2 u_buf (
      .i_clk     (I_MCLK),
      .i_rstn    (I_RSTN),
      .i_valid   (buf_in_valid),
      .o_ready   (buf_in_ready),
      .i_data    (tx_in),
      .o_valid   (buf_out_valid),
      .i_ready   (drv_ready),
      .o_data    (buf_out_data)
   );

   // Outputs decoded from state, all registered
   always @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_BUS_DRV_DOM     <= 1'b0;
         O_RX_DATA_OUT     <= 1'b1;
         O_RX_DATA_OE      <= 1'b0;
         O_TX_DATA_OUT     <= 1'b1;
         O_TX_DATA_OE      <= 1'b0;
         O_RESET_OUT_N_OUT <= 1'b0;
         O_RESET_OUT_N_OE  <= 1'b1;
         O_REG_ON          <= 1'b0;
         O_INH             <= 1'b0;
         O_WAKE_SRC        <= `LMC_WSRC_NONE;
      end else begin
         O_BUS_DRV_DOM <= (state_reg == ST_NORM) & bat_ok & ~dom_lock_reg &
                          buf_out_valid & ~buf_out_data & buf_in_ready;
         O_RX_DATA_OE  <= (state_reg != ST_UNPWR);
         case (state_reg)
            ST_NORM:  O_RX_DATA_OUT <= bus_in;
            ST_FSAFE: O_RX_DATA_OUT <= ~rwake_reg;
            ST_SLEEP: O_RX_DATA_OUT <= 1'b0;
            default:  O_RX_DATA_OUT <= 1'b1;
         endcase
         O_TX_DATA_OE  <= (state_reg == ST_FSAFE) &
                          ((wsrc_reg == `LMC_WSRC_LOCAL) | (wsrc_reg == `LMC_WSRC_IGN));
         O_TX_DATA_OUT <= 1'b0;
         O_RESET_OUT_N_OUT <= 1'b0;
         O_RESET_OUT_N_OE  <= rst_low | (state_reg == ST_SLEEP);
         O_REG_ON <= (state_reg == ST_FSAFE) | (state_reg == ST_NORM) |
                     (state_reg == ST_SILNT);
         O_INH    <= ((state_reg == ST_FSAFE) | (state_reg == ST_NORM)) & ~rst_low;
         O_WAKE_SRC <= wsrc_reg;
      end
   end
endmodule // lmc_top

// Two-entry valid/ready buffer
module lmc_buf2 (
   input  wire i_clk,
   input  wire i_rstn,
   input  wire i_valid,
   output wire o_ready,
   input  wire i_data,
   output wire o_valid,
   input  wire i_ready,
   output wire o_data
);
   reg [`LMC_BUF_W-1:0] mem_reg;
   reg [1:0]            cnt_reg;
   reg                  rd_reg;
   reg                  wr_reg;
   wire push = i_valid & o_ready;
   wire pop  = o_valid & i_ready;

   assign o_ready = (cnt_reg != 2'h2);
   assign o_valid = (cnt_reg != 2'h0);
   assign o_data  = mem_reg[rd_reg];

   // Pointer and storage update; stalled reader lets the buffer fill
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         mem_reg <= 2'h3;
         cnt_reg <= 2'h0;
         rd_reg  <= 1'b0;
         wr_reg  <= 1'b0;
      end else begin
         if (push) begin
            mem_reg[wr_reg] <= i_data;
            wr_reg          <= ~wr_reg;
         end
         if (pop) begin
            rd_reg <= ~rd_reg;
         end
         if (push && !pop) begin
            cnt_reg <= cnt_reg + 2'h1;
         end else if (pop && !push) begin
            cnt_reg <= cnt_reg - 2'h1;
         end
      end
   end
endmodule // lmc_buf2

/* lmc_defines.vh */
`ifndef LMC_DEFINES_VH
`define LMC_DEFINES_VH
// Clock period in ns (100 MHz)
`define LMC_CLK_PERIOD_NS   100'd10
// Times as given, in microseconds
`define LMC_DOMINANT_TIMEOUT_US        6000
`define LMC_T_TXREL_US      10
`define LMC_T_RES_US        4000
`define LMC_T_DB_IGN_US     160
`define LMC_T_BUS_WAKE_US   30
`define LMC_T_WDOG_US       20000
// Cycle counts of the times above at 100 MHz, sized to their counters
`define LMC_DOM_CYC      20'h927C0
`define LMC_TXREL_CYC    20'h003E8
`define LMC_RES_CYC      20'h61A80
`define LMC_DB_IGN_CYC   20'h03E80
`define LMC_BUS_WAKE_CYC 20'h00BB8
`define LMC_WDOG_CYC     22'h1E8480
// Wake source codes
`define LMC_WSRC_NONE    2'h0
`define LMC_WSRC_BUS     2'h1
`define LMC_WSRC_LOCAL   2'h2
`define LMC_WSRC_IGN     2'h3
// Buffer geometry
`define LMC_BUF_W        2
`endif

/* lmc_sync3.v */
`timescale 1ns/1ps
`include "lmc_defines.vh"
// Three-stage synchroniser; output changes once stages two and three agree
module lmc_sync3 #(
   parameter RST_VAL = 1'b1
) (
   input  wire i_clk,
   input  wire i_rstn,
   input  wire i_d,
   output reg  o_q
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;

   // Stage one is read only by stage two
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
         o_q    <= RST_VAL;
      end else begin
         s1_reg <= i_d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            o_q <= s3_reg;
         end
      end
   end
endmodule // lmc_sync3

/* lmc_top_asserts.sv */
`timescale 1ns/1ps
// Pin-level checks; 8-cycle runs cover the input synchronisers
module lmc_top_asserts #(
   // Longest dominant run: the time-out plus synchroniser and register delay
   parameter int DOM_MAX = 600010
) (
   input wire       I_MCLK,
   input wire       I_RSTN,
   input wire       I_BATTERY_OK,
   input wire       I_VCC_OK,
   input wire       I_TX_DATA_IN,
   input wire       I_ENABLE,
   input wire       I_LOCAL_WAKE_N,
   input wire       I_IGNITION_WAKE_IN,
   input wire       I_WDOG_MODE,
   input wire       I_WDOG_TRIGGER_N,
   input wire       I_BUS_IN,
   input wire       O_BUS_DRV_DOM,
   input wire       O_RX_DATA_OUT,
   input wire       O_RX_DATA_OE,
   input wire       O_TX_DATA_OUT,
   input wire       O_TX_DATA_OE,
   input wire       O_RESET_OUT_N_OUT,
   input wire       O_RESET_OUT_N_OE,
   input wire       O_REG_ON,
   input wire       O_INH,
   input wire [1:0] O_WAKE_SRC
);
   reg [19:0] dom_cnt_reg;

   // Length of the current dominant run
   always @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN)
         dom_cnt_reg <= 20'h00000;
      else
         dom_cnt_reg <= O_BUS_DRV_DOM ? dom_cnt_reg + 20'h00001 : 20'h00000;
   end

   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (!I_RSTN);

   AST_BATT_BLOCK: assert property (!I_BATTERY_OK [*8] |-> !O_BUS_DRV_DOM)
      else $error("driver on with battery low");
   AST_UNPOW_RX: assert property (!I_BATTERY_OK [*8] |-> !O_RX_DATA_OE)
      else $error("rx driven while unpowered");
   AST_VCC_RESET: assert property (!I_VCC_OK [*8] |-> O_RESET_OUT_N_OE)
      else $error("no reset on regulator undervoltage");
   AST_OD_LOW: assert property (O_RESET_OUT_N_OE |-> !O_RESET_OUT_N_OUT)
      else $error("reset pin driven high");
   AST_TX_REC: assert property (I_TX_DATA_IN [*8] |-> !O_BUS_DRV_DOM)
      else $error("dominant while tx high");
   AST_RX_DOM: assert property ((O_BUS_DRV_DOM && !I_BUS_IN) [*8] |-> !O_RX_DATA_OUT)
      else $error("rx high on dominant bus");
   AST_DOM_MAX: assert property (dom_cnt_reg <= DOM_MAX)
      else $error("dominant beyond time-out");
   AST_RELOCK: assert property ($fell(O_BUS_DRV_DOM) && !I_TX_DATA_IN |=> !O_BUS_DRV_DOM [*8])
      else $error("driver back on while tx low");
   AST_FS_TX: assert property (O_TX_DATA_OE |-> !O_TX_DATA_OUT && !O_BUS_DRV_DOM)
      else $error("tx pin output not low");
   AST_NORMAL_ONLY: assert property (O_BUS_DRV_DOM |-> O_REG_ON && !O_TX_DATA_OE && O_RX_DATA_OE)
      else $error("driver on outside normal");
   AST_SLEEP_OFF: assert property (!O_REG_ON |-> !O_BUS_DRV_DOM && !O_INH)
      else $error("activity with regulator off");
endmodule // lmc_top_asserts

bind lmc_top lmc_top_asserts #(.DOM_MAX(DOM_CYC + 10)) u_lmc_top_asserts (.I_MCLK(I_MCLK),
   .I_RSTN(I_RSTN),
   .I_BATTERY_OK(I_BATTERY_OK), .I_VCC_OK(I_VCC_OK), .I_TX_DATA_IN(I_TX_DATA_IN),
   .I_ENABLE(I_ENABLE), .I_LOCAL_WAKE_N(I_LOCAL_WAKE_N),
   .I_IGNITION_WAKE_IN(I_IGNITION_WAKE_IN), .I_WDOG_MODE(I_WDOG_MODE),
   .I_WDOG_TRIGGER_N(I_WDOG_TRIGGER_N), .I_BUS_IN(I_BUS_IN),
   .O_BUS_DRV_DOM(O_BUS_DRV_DOM), .O_RX_DATA_OUT(O_RX_DATA_OUT),
   .O_RX_DATA_OE(O_RX_DATA_OE), .O_TX_DATA_OUT(O_TX_DATA_OUT),
   .O_TX_DATA_OE(O_TX_DATA_OE), .O_RESET_OUT_N_OUT(O_RESET_OUT_N_OUT),
   .O_RESET_OUT_N_OE(O_RESET_OUT_N_OE), .O_REG_ON(O_REG_ON), .O_INH(O_INH),
   .O_WAKE_SRC(O_WAKE_SRC));

/* lmc_bus_model.sv */
`timescale 1ns/1ps
// Bus line: wired-AND of our driver and other nodes
module lmc_bus_model (
   input  wire i_drv_dom,
   input  wire i_remote_dom,
   output wire o_bus
);
   // Pull-up leaves the line recessive when nobody pulls it down
   assign o_bus = ~(i_drv_dom | i_remote_dom);
endmodule // lmc_bus_model

/* testbench.sv */
`timescale 1ns/1ps
`include "lmc_defines.vh"
module testbench;
   localparam int LIMIT = 80000;
   // One cycle stands for one microsecond so that the run stays short
   localparam int DOM   = `LMC_DOMINANT_TIMEOUT_US;
   localparam int TXREL = `LMC_T_TXREL_US;
   localparam int RES   = `LMC_T_RES_US;
   localparam int IGN   = `LMC_T_DB_IGN_US;
   localparam int BUSW  = `LMC_T_BUS_WAKE_US;
   localparam int WDOG  = `LMC_T_WDOG_US;
   logic       mclk, rstn, battery_ok, vcc_ok, host_tx, enable;
   logic       local_wake_n, ign, wdog_trig_n, remote_dom, wdog_mode, trig_on;
   wire        tx_pin, bus, drv_dom, rx_out, rx_oe, tx_out, tx_oe;
   wire        rst_out, rst_oe, reg_on, inh;
   wire [1:0]  wake_src;
   int         fail_count, n_checks, cyc_count;

   // Device owns the tx pin in Fail-safe after a local or ignition wake, so the host lets go of it
   assign tx_pin = tx_oe ? tx_out : host_tx;

   lmc_top #(.DOM_CYC(20'(DOM)), .TXREL_CYC(20'(TXREL)), .RES_CYC(20'(RES)),
      .IGN_CYC(20'(IGN)), .BUSW_CYC(20'(BUSW)), .WDOG_CYC(22'(WDOG)))
      u_lmc_top (.I_MCLK(mclk), .I_RSTN(rstn), .I_BATTERY_OK(battery_ok),
      .I_VCC_OK(vcc_ok), .I_TX_DATA_IN(tx_pin), .I_ENABLE(enable),
      .I_LOCAL_WAKE_N(local_wake_n), .I_IGNITION_WAKE_IN(ign), .I_WDOG_MODE(wdog_mode),
      .I_WDOG_TRIGGER_N(wdog_trig_n), .I_BUS_IN(bus), .O_BUS_DRV_DOM(drv_dom),
      .O_RX_DATA_OUT(rx_out), .O_RX_DATA_OE(rx_oe), .O_TX_DATA_OUT(tx_out),
      .O_TX_DATA_OE(tx_oe), .O_RESET_OUT_N_OUT(rst_out), .O_RESET_OUT_N_OE(rst_oe),
      .O_REG_ON(reg_on), .O_INH(inh), .O_WAKE_SRC(wake_src));
   lmc_bus_model u_lmc_bus_model (.i_drv_dom(drv_dom), .i_remote_dom(remote_dom),
      .o_bus(bus));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Hang guard, plus a watchdog trigger well inside its time-out
   always @(posedge mclk) begin
      cyc_count <= cyc_count + 1;
      wdog_trig_n <= !trig_on || (cyc_count % 5000) >= 50;
      if (cyc_count == LIMIT) begin
         fail_count = fail_count + 1;
         test_done();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic chk(input logic got, input logic exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s", $time, msg);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Enable high; the reset pulse may hold the mode for up to 4 ms first
   task automatic go_normal();
      int i;
      enable <= 1'b1;
      for (i = 0; i < RES + 100 && rst_oe !== 1'b0; i++)
         @(posedge mclk);
      cyc(12);
      chk(rst_oe, 1'b0, "reset pulse stuck");
      chk(reg_on & inh & ~tx_oe, 1'b1, "normal outputs");
   endtask

   task automatic t_reset();
      chk(rst_oe & rx_out, 1'b1, "reset pin or rx in reset");
      chk(reg_on | inh | drv_dom | rx_oe | tx_oe, 1'b0, "outputs in reset");
      rstn <= 1'b1;
      cyc(12);
      chk(reg_on & ~inh & rst_oe & rx_out & rx_oe & ~drv_dom, 1'b1, "fail-safe at power-up");
      host_tx <= 1'b0;
      cyc(12);
      chk(drv_dom, 1'b0, "fail-safe transmits");
      host_tx <= 1'b1;
      $display("test reset done");
   endtask

   task automatic t_normal();
      go_normal();
      host_tx <= 1'b0;
      cyc(8);
      chk(drv_dom, 1'b1, "tx low not dominant");
      cyc(8);
      chk(rx_out, 1'b0, "rx not low");
      host_tx <= 1'b1;
      cyc(16);
      chk(drv_dom | ~rx_out, 1'b0, "recessive not mirrored");
      remote_dom <= 1'b1;
      cyc(10);
      chk(rx_out, 1'b0, "remote dominant unseen");
      remote_dom <= 1'b0;
      cyc(10);
      $display("test normal done");
   endtask

   task automatic dominant_timeout();
      host_tx <= 1'b0;
      cyc(DOM - 10);
      chk(drv_dom, 1'b1, "released early");
      cyc(30);
      chk(drv_dom, 1'b0, "not released");
      host_tx <= 1'b1;
      cyc(8);
      host_tx <= 1'b0;
      cyc(12);
      chk(drv_dom, 1'b0, "short high rearmed");
      host_tx <= 1'b1;
      cyc(TXREL + 20);
      host_tx <= 1'b0;
      cyc(10);
      chk(drv_dom, 1'b1, "not rearmed");
      host_tx <= 1'b1;
      cyc(10);
      $display("test time-out done");
   endtask

   task automatic t_silent();
      enable <= 1'b0;
      cyc(12);
      chk(reg_on & ~inh, 1'b1, "silent outputs");
      host_tx <= 1'b0;
      cyc(12);
      chk(drv_dom, 1'b0, "silent transmits");
      host_tx <= 1'b1;
      local_wake_n <= 1'b0;
      cyc(16);
      chk(tx_oe & ~tx_out, 1'b1, "tx not latched low");
      chk(wake_src === `LMC_WSRC_LOCAL, 1'b1, "source not local");
      local_wake_n <= 1'b1;
      go_normal();
      enable <= 1'b0;
      cyc(12);
      remote_dom <= 1'b1;
      cyc(BUSW + 100);
      remote_dom <= 1'b0;
      cyc(16);
      chk(rx_out | tx_oe, 1'b0, "remote wake not flagged");
      chk(wake_src === `LMC_WSRC_BUS, 1'b1, "source not bus");
      go_normal();
      chk(rx_out, 1'b1, "wake flag kept");
      $display("test silent done");
   endtask

   task automatic t_vcc();
      host_tx <= 1'b0;
      cyc(10);
      vcc_ok <= 1'b0;
      cyc(10);
      chk(rst_oe & ~drv_dom, 1'b1, "no undervoltage reset");
      vcc_ok <= 1'b1;
      host_tx <= 1'b1;
      enable <= 1'b0;
      cyc(12);
      chk(rst_oe & reg_on, 1'b1, "reset pulse missing");
      go_normal();
      $display("test undervoltage done");
   endtask

   task automatic t_sleep();
      host_tx <= 1'b0;
      enable <= 1'b0;
      cyc(16);
      chk(reg_on | inh | drv_dom, 1'b0, "sleep outputs");
      host_tx <= 1'b1;
      ign <= 1'b1;
      cyc(IGN - 10);
      chk(reg_on, 1'b0, "woke before debounce");
      cyc(20);
      chk(reg_on & tx_oe & ~tx_out, 1'b1, "no ignition wake");
      chk(wake_src === `LMC_WSRC_IGN, 1'b1, "source not ignition");
      ign <= 1'b0;
      go_normal();
      host_tx <= 1'b0;
      cyc(10);
      battery_ok <= 1'b0;
      cyc(10);
      chk(drv_dom | rx_oe, 1'b0, "battery low");
      battery_ok <= 1'b1;
      host_tx <= 1'b1;
      enable <= 1'b0;
      cyc(12);
      chk(reg_on & rst_oe, 1'b1, "no fail-safe on supply");
      $display("test sleep done");
   endtask

   // Missing triggers give a reset; the mode pin switches the watchdog off
   task automatic t_wdog();
      go_normal();
      trig_on <= 1'b0;
      cyc(WDOG - 5100);
      chk(rst_oe, 1'b0, "watchdog reset early");
      cyc(5200);
      chk(rst_oe & ~inh, 1'b1, "no watchdog reset");
      wdog_mode <= 1'b1;
      go_normal();
      cyc(WDOG + 100);
      chk(rst_oe, 1'b0, "watchdog not disabled");
      wdog_mode <= 1'b0;
      trig_on <= 1'b1;
      $display("test watchdog done");
   endtask

   initial begin
      rstn = 1'b0;
      battery_ok = 1'b1;
      vcc_ok = 1'b1;
      host_tx = 1'b1;
      enable = 1'b0;
      local_wake_n = 1'b1;
      ign = 1'b0;
      wdog_trig_n = 1'b1;
      remote_dom = 1'b0;
      wdog_mode = 1'b0;
      trig_on = 1'b1;
      fail_count = 0;
      n_checks = 0;
      cyc_count = 0;
      cyc(8);
      t_reset();
      t_normal();
      dominant_timeout();
      t_silent();
      t_vcc();
      t_sleep();
      t_wdog();
      test_done();
   end
endmodule // testbench
